// [inc/cpg_consts.svh]
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH
// register indices; byte address is four times the index
`define CPG_IDX_GAIN 8'h04
`define CPG_IDX_PWR 8'h05
`define CPG_IDX_IRQ_STAT 8'h10
`define CPG_IDX_IRQ_MASK 8'h11
// gain step register fields
`define CPG_GAIN_FLAG_BIT 0
`define CPG_GAIN_DSLOW_BIT 1
`define CPG_GAIN_REFSEL_BIT 2
`define CPG_GAIN_ISLOW_BIT 3
// power control register fields
`define CPG_PWR_OFF_LSB 6
`define CPG_PWR_DONE_LSB 2
`define CPG_PWR_FX_BIT 1
`define CPG_PWR_DEEMPH_BIT 0
// reset values
`define CPG_PWR_OFF_RST 10'h3ff
`define CPG_DONE_RST 4'hf
`define CPG_GAIN_RST 7'h00
// one gain code is 0.5 dB; code zero is the -12 dB floor
`define CPG_GAIN_STEP 7'h01
`define CPG_AGC_FLOOR 7'h00
`define CPG_AGC_CEIL 7'h7f
// interrupt status bit positions
`define CPG_EV_SETTLED 0
`define CPG_EV_SAT 1
`define CPG_EV_DONE_LSB 2
`endif

// [inc/cpg_pkg.sv]
package cpg_pkg;
  typedef logic [6:0] cpg_gain_t;

  // complete register state of the block
  typedef struct packed {
    logic [9:0] pwr_off;
    logic fx_en;
    logic deemph_en;
    logic dac_slow;
    logic in_slow;
    logic in_ref_sel;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    logic irq;
    logic [1:0] ws_sync;
    logic [1:0] rws_sync;
    logic ws_prev;
    logic rws_prev;
    logic dac_half;
    logic in_half;
    logic [3:0] done_s1;
    logic [3:0] done_s2;
    logic [3:0] done_prev;
    cpg_gain_t dac_gain;
    cpg_gain_t in_gain;
    logic settled;
    logic sat;
    logic full_off;
    logic ack;
    logic [31:0] dat;
  } cpg_state_s;
endpackage

// [hdl/cpg_power_gain.sv]
`timescale 1ns/100ps
`include "cpg_consts.svh"

// Overview of operation
// - dac step rate bit: one or two periods
// - settled flag: applied input gain equals programmed
// - under agc, flag reports gain limit saturation
// - mic bias off bits, reset to one
// - sidetone off bit, reset to one
// - two speaker off bits, reset to one
// - playback and record converter off bits
// - virtual ground off bit, reset one
// - cellphone output off bit, reset one
// - loudspeaker off bit, reset one
// - record converter off done flag, read only
// - left and right playback done flags
// - sidetone off done flag, read only
// - effects filter enable, reset zero
// - deemphasis enable, reset zero
// - all ten off bits mean full off
// - input steps on word or record clock
module cpg_power_gain #(
  parameter cpg_pkg::cpg_gain_t AGC_FLOOR = `CPG_AGC_FLOOR,
  parameter cpg_pkg::cpg_gain_t AGC_CEIL = `CPG_AGC_CEIL
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  input wire logic word_clock_i,
  input wire logic record_word_select_i,
  input wire logic [3:0] off_done_i,
  input wire logic automatic_gain_control_i,
  input wire cpg_pkg::cpg_gain_t dac_gain_target_i,
  input wire cpg_pkg::cpg_gain_t input_gain_target_i,
  output logic [9:0] codec_off_o,
  output logic codec_full_off_o,
  output logic effects_filter_enable_o,
  output logic deemphasis_enable_o,
  output cpg_pkg::cpg_gain_t dac_gain_applied_o,
  output cpg_pkg::cpg_gain_t input_gain_applied_o
);
  import cpg_pkg::*;

  cpg_state_s st;
  cpg_state_s next_st;
  logic access;
  logic wr;
  logic [7:0] idx;
  logic ws_tick;
  logic rws_tick;
  logic in_tick;
  logic gain_flag;
  logic [5:0] events;
  logic [31:0] rdata;
  logic [15:0] wmask;

  // bus decode
  assign access = cyc_i & stb_i & ~st.ack;
  assign wr = access & we_i;
  assign idx = adr_i[9:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // word clock edges, read only from the second sync stage
  assign ws_tick = st.ws_sync[1] & ~st.ws_prev;
  assign rws_tick = st.rws_sync[1] & ~st.rws_prev;
  assign in_tick = st.in_ref_sel ? rws_tick : ws_tick;

  // flag bit meaning depends on automatic gain control
  assign gain_flag = automatic_gain_control_i ? st.sat : st.settled;

  // event sources for the interrupt status
  always_comb begin
    events = 6'h00;
    // built from current state and inputs only, so no loop through next_st
    events[`CPG_EV_SETTLED] = (st.in_gain == input_gain_target_i) & ~st.settled;
    events[`CPG_EV_SAT] = automatic_gain_control_i
      & ((st.in_gain == AGC_FLOOR) | (st.in_gain == AGC_CEIL)) & ~st.sat;
    events[`CPG_EV_DONE_LSB +: 4] = st.done_s2 & ~st.done_prev;
  end

  // read data mux, unmapped reads return zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      `CPG_IDX_GAIN: begin
        rdata[`CPG_GAIN_FLAG_BIT] = gain_flag;
        rdata[`CPG_GAIN_DSLOW_BIT] = st.dac_slow;
        rdata[`CPG_GAIN_REFSEL_BIT] = st.in_ref_sel;
        rdata[`CPG_GAIN_ISLOW_BIT] = st.in_slow;
      end
      `CPG_IDX_PWR: begin
        rdata[`CPG_PWR_OFF_LSB +: 10] = st.pwr_off;
        rdata[`CPG_PWR_DONE_LSB +: 4] = st.done_s2;
        rdata[`CPG_PWR_FX_BIT] = st.fx_en;
        rdata[`CPG_PWR_DEEMPH_BIT] = st.deemph_en;
      end
      `CPG_IDX_IRQ_STAT: begin
        rdata[5:0] = st.irq_stat;
      end
      `CPG_IDX_IRQ_MASK: begin
        rdata[5:0] = st.irq_mask;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_st = st;
    // bus answer: one cycle ack, dropped the cycle after
    next_st.ack = access;
    next_st.dat = access ? rdata : 32'h0000_0000;

    // synchronisers for pin inputs
    next_st.ws_sync = {st.ws_sync[0], word_clock_i};
    next_st.rws_sync = {st.rws_sync[0], record_word_select_i};
    next_st.ws_prev = st.ws_sync[1];
    next_st.rws_prev = st.rws_sync[1];
    next_st.done_s1 = off_done_i;
    next_st.done_s2 = st.done_s1;
    next_st.done_prev = st.done_s2;

    // register writes; flag bits are not writable
    if (wr) begin
      case (idx)
        `CPG_IDX_GAIN: begin
          if (sel_i[0]) begin
            next_st.dac_slow = dat_i[`CPG_GAIN_DSLOW_BIT];
            next_st.in_ref_sel = dat_i[`CPG_GAIN_REFSEL_BIT];
            next_st.in_slow = dat_i[`CPG_GAIN_ISLOW_BIT];
          end
        end
        `CPG_IDX_PWR: begin
          // only the writable fields take data
          next_st.pwr_off = (st.pwr_off & ~wmask[15:6])
            | (dat_i[15:6] & wmask[15:6]);
          if (sel_i[0]) begin
            next_st.fx_en = dat_i[`CPG_PWR_FX_BIT];
            next_st.deemph_en = dat_i[`CPG_PWR_DEEMPH_BIT];
          end
        end
        `CPG_IDX_IRQ_MASK: begin
          if (sel_i[0]) begin
            next_st.irq_mask = dat_i[5:0];
          end
        end
        default: begin
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end

    // write one to clear, a new event wins over the clear
    if (wr && idx == `CPG_IDX_IRQ_STAT && sel_i[0]) begin
      next_st.irq_stat = (st.irq_stat & ~dat_i[5:0]) | events;
    end else begin
      next_st.irq_stat = st.irq_stat | events;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    // dac gain soft step: every period or every second period
    if (ws_tick) begin
      next_st.dac_half = ~st.dac_half;
      if (!st.dac_slow || st.dac_half) begin
        if (st.dac_gain < dac_gain_target_i) begin
          next_st.dac_gain = st.dac_gain + `CPG_GAIN_STEP;
        end else if (st.dac_gain > dac_gain_target_i) begin
          next_st.dac_gain = st.dac_gain - `CPG_GAIN_STEP;
        end
      end
    end

    // input gain soft step on the selected reference clock
    if (in_tick) begin
      next_st.in_half = ~st.in_half;
      if (!st.in_slow || st.in_half) begin
        if (st.in_gain < input_gain_target_i) begin
          next_st.in_gain = st.in_gain + `CPG_GAIN_STEP;
        end else if (st.in_gain > input_gain_target_i) begin
          next_st.in_gain = st.in_gain - `CPG_GAIN_STEP;
        end
      end
    end

    // gain status flags
    next_st.settled = (st.in_gain == input_gain_target_i);
    next_st.sat = automatic_gain_control_i
      & ((st.in_gain == AGC_FLOOR) | (st.in_gain == AGC_CEIL));

    // whole codec off when every off bit is set
    next_st.full_off = &next_st.pwr_off;
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.pwr_off <= `CPG_PWR_OFF_RST;
      st.done_s1 <= `CPG_DONE_RST;
      st.done_s2 <= `CPG_DONE_RST;
      st.done_prev <= `CPG_DONE_RST;
      st.dac_gain <= `CPG_GAIN_RST;
      st.in_gain <= `CPG_GAIN_RST;
      st.full_off <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign dat_o = st.dat;
  assign ack_o = st.ack;
  assign irq_o = st.irq;
  assign codec_off_o = st.pwr_off;
  assign codec_full_off_o = st.full_off;
  assign effects_filter_enable_o = st.fx_en;
  assign deemphasis_enable_o = st.deemph_en;
  assign dac_gain_applied_o = st.dac_gain;
  assign input_gain_applied_o = st.in_gain;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_full_off_all: assert property (codec_full_off_o == &codec_off_o)
    else $error("full off does not match off bits");
  a_pwr_write_takes: assert property (wr && idx == `CPG_IDX_PWR && (&sel_i[1:0])
    |=> codec_off_o == $past(dat_i[15:6]))
    else $error("power off bits did not take write");
  a_fx_write: assert property (wr && idx == `CPG_IDX_PWR && sel_i[0]
    |=> effects_filter_enable_o == $past(dat_i[1]) && deemphasis_enable_o == $past(dat_i[0]))
    else $error("filter enables did not take write");
  a_done_ro: assert property (wr && idx == `CPG_IDX_PWR
    |=> st.done_s2 == $past(st.done_s1))
    else $error("done flags altered by write");
  a_dac_fast_step: assert property (ws_tick && !st.dac_slow && st.dac_gain < dac_gain_target_i
    |=> dac_gain_applied_o == $past(st.dac_gain) + 7'h01)
    else $error("dac gain did not step");
  a_dac_slow_hold: assert property (ws_tick && st.dac_slow && !st.dac_half
    |=> $stable(dac_gain_applied_o))
    else $error("slow dac step moved early");
  a_in_ref_sel: assert property (!in_tick |=> $stable(input_gain_applied_o))
    else $error("input gain moved without reference tick");
  a_settled_flag: assert property (!automatic_gain_control_i
    && input_gain_applied_o == input_gain_target_i |=> st.settled)
    else $error("settled flag not set");
  a_sat_flag: assert property (automatic_gain_control_i && st.in_gain == AGC_FLOOR
    |=> st.sat)
    else $error("saturation not reported");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_irq_level: assert property (irq_o == |(st.irq_stat & st.irq_mask))
    else $error("irq does not follow masked status");

  // bus answer and read path
  a_ack_follows: assert property (access |=> ack_o)
    else $error("taken request not acked");
  a_ack_idle: assert property (!access |=> !ack_o)
    else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_dat_upper: assert property (dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_read_pwr: assert property (access && !we_i && idx == `CPG_IDX_PWR
    |=> dat_o[15:0] == {$past(st.pwr_off), $past(st.done_s2), $past(st.fx_en), $past(st.deemph_en)})
    else $error("power register read wrong");
  a_read_flag: assert property (access && !we_i && idx == `CPG_IDX_GAIN
    |=> dat_o[0] == $past(gain_flag))
    else $error("gain flag read wrong");

  // register writes and holds
  a_pwr_hold: assert property (!(wr && idx == `CPG_IDX_PWR) |=> $stable(codec_off_o))
    else $error("power off bits moved without write");
  a_fx_hold: assert property (!(wr && idx == `CPG_IDX_PWR)
    |=> $stable(effects_filter_enable_o) && $stable(deemphasis_enable_o))
    else $error("filter enables moved without write");
  a_pwr_upper_byte: assert property (wr && idx == `CPG_IDX_PWR && sel_i[1] && !sel_i[0]
    |=> codec_off_o[1:0] == $past(codec_off_o[1:0]) && codec_off_o[9:2] == $past(dat_i[15:8]))
    else $error("byte enable on power bits wrong");
  a_full_off_clear: assert property (!(&codec_off_o) |-> !codec_full_off_o)
    else $error("full off set with a bit clear");
  a_dslow_write: assert property (wr && idx == `CPG_IDX_GAIN && sel_i[0]
    |=> st.dac_slow == $past(dat_i[1]))
    else $error("dac step rate did not take write");
  a_refsel_write: assert property (wr && idx == `CPG_IDX_GAIN && sel_i[0]
    |=> st.in_ref_sel == $past(dat_i[2]))
    else $error("reference select did not take write");
  a_flag_ro: assert property (wr && idx == `CPG_IDX_GAIN
    |=> st.settled == $past(st.in_gain == input_gain_target_i))
    else $error("settled flag altered by write");

  // interrupt status and mask
  a_mask_write: assert property (wr && idx == `CPG_IDX_IRQ_MASK && sel_i[0]
    |=> st.irq_mask == $past(dat_i[5:0]))
    else $error("mask did not take write");
  a_stat_clear: assert property (wr && idx == `CPG_IDX_IRQ_STAT && sel_i[0] && dat_i[0]
    && !events[0] |=> !st.irq_stat[0])
    else $error("status bit not cleared");
  a_stat_sticky: assert property (st.irq_stat[0]
    && !(wr && idx == `CPG_IDX_IRQ_STAT && sel_i[0] && dat_i[0]) |=> st.irq_stat[0])
    else $error("status bit lost");
  a_event_wins: assert property (events[`CPG_EV_SAT] |=> st.irq_stat[`CPG_EV_SAT])
    else $error("event lost against clear");
  a_irq_needs_mask: assert property (irq_o |-> |st.irq_mask)
    else $error("irq with empty mask");

  // gain stepping
  a_dac_fast_down: assert property (ws_tick && !st.dac_slow && st.dac_gain > dac_gain_target_i
    |=> dac_gain_applied_o == $past(st.dac_gain) - 7'h01)
    else $error("dac gain did not step down");
  a_dac_slow_step: assert property (ws_tick && st.dac_slow && st.dac_half
    && st.dac_gain < dac_gain_target_i |=> dac_gain_applied_o == $past(st.dac_gain) + 7'h01)
    else $error("slow dac step missing");
  a_dac_no_tick: assert property (!ws_tick |=> $stable(dac_gain_applied_o))
    else $error("dac gain moved without tick");
  a_ws_single: assert property (ws_tick |=> !ws_tick)
    else $error("word tick longer than one cycle");
  a_rws_single: assert property (rws_tick |=> !rws_tick)
    else $error("record tick longer than one cycle");
  a_in_ref_word: assert property (in_tick && !st.in_ref_sel |-> ws_tick)
    else $error("input stepped off word clock");
  a_in_ref_rec: assert property (in_tick && st.in_ref_sel |-> rws_tick)
    else $error("input stepped off record clock");
  a_in_fast_step: assert property (in_tick && !st.in_slow && st.in_gain < input_gain_target_i
    |=> input_gain_applied_o == $past(st.in_gain) + 7'h01)
    else $error("input gain did not step");
  a_in_slow_hold: assert property (in_tick && st.in_slow && !st.in_half
    |=> $stable(input_gain_applied_o))
    else $error("slow input step moved early");

  // gain flags
  a_settled_clear: assert property (input_gain_applied_o != input_gain_target_i
    |=> !st.settled)
    else $error("settled flag while stepping");
  a_sat_ceiling: assert property (automatic_gain_control_i && st.in_gain == AGC_CEIL
    |=> st.sat)
    else $error("ceiling saturation not reported");
  a_sat_mid: assert property (automatic_gain_control_i && st.in_gain != AGC_FLOOR
    && st.in_gain != AGC_CEIL |=> !st.sat)
    else $error("saturation reported inside range");
  a_sat_off: assert property (!automatic_gain_control_i |=> !st.sat)
    else $error("saturation without gain control");

  c_full_power_up: cover property (codec_full_off_o ##1 !codec_full_off_o);
  c_dac_settle: cover property (ws_tick && st.dac_slow ##[1:50] dac_gain_applied_o == dac_gain_target_i);
  c_sat_event: cover property (st.irq_stat[`CPG_EV_SAT] && irq_o);
  c_done_rise: cover property (events[`CPG_EV_DONE_LSB]);
endmodule // cpg_power_gain

// [sim/testbench.sv]
`timescale 1ns/100ps

module testbench;
  import cpg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, irq_o, codec_full_off_o, effects_filter_enable_o, deemphasis_enable_o;
  logic word_clock_i = 1'b0;
  logic record_word_select_i = 1'b0;
  logic [3:0] off_done_i = 4'hf;
  logic automatic_gain_control_i = 1'b0;
  cpg_gain_t dac_gain_target_i = 7'h04;
  cpg_gain_t input_gain_target_i = 7'h05;
  logic [9:0] codec_off_o;
  cpg_gain_t dac_gain_applied_o, input_gain_applied_o;
  logic [31:0] q;
  int fail_count = 0;
  int compares = 0;

  cpg_power_gain i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .word_clock_i(word_clock_i), .record_word_select_i(record_word_select_i), .off_done_i(off_done_i),
    .automatic_gain_control_i(automatic_gain_control_i), .dac_gain_target_i(dac_gain_target_i),
    .input_gain_target_i(input_gain_target_i), .codec_off_o(codec_off_o),
    .codec_full_off_o(codec_full_off_o), .effects_filter_enable_o(effects_filter_enable_o),
    .deemphasis_enable_o(deemphasis_enable_o), .dac_gain_applied_o(dac_gain_applied_o),
    .input_gain_applied_o(input_gain_applied_o));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare one value with its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      conclude();
    end else begin
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
    end
  endtask

  // one record word select period on the pin
  task automatic rtick(input int count);
    repeat (count) begin
      record_word_select_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      record_word_select_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask

  // one word clock period on the pin, slow enough for the synchroniser
  task automatic tick(input int count);
    repeat (count) begin
      word_clock_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      word_clock_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values of the power and gain registers
    wb(1'b0, 10'h014, 16'h0000, 4'h0, q);
    check(q, 32'h0000_fffc);
    check(codec_full_off_o, 1'b1);
    wb(1'b0, 10'h010, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0000);
    $display("test reset values done");
    // power bits, read only flags, byte enables
    wb(1'b1, 10'h014, 16'h0000, 4'h3, q);
    check(codec_off_o, 10'h000);
    check(codec_full_off_o, 1'b0);
    wb(1'b1, 10'h014, 16'hffff, 4'h3, q);
    check(codec_full_off_o, 1'b1);
    check({effects_filter_enable_o, deemphasis_enable_o}, 2'b11);
    wb(1'b1, 10'h014, 16'h0000, 4'h2, q);
    check(codec_off_o, 10'h003);
    wb(1'b0, 10'h014, 16'h0000, 4'h0, q);
    check(q, 32'h0000_00ff);
    off_done_i <= 4'ha;
    repeat (5) @(posedge clk_i);
    wb(1'b0, 10'h014, 16'h0000, 4'h0, q);
    check(q, 32'h0000_00eb);
    off_done_i <= 4'hf;
    $display("test power control done");
    // saturation under agc, then soft stepping
    automatic_gain_control_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(1'b0, 10'h010, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0001);
    automatic_gain_control_i <= 1'b0;
    wb(1'b1, 10'h010, 16'h0003, 4'h1, q);
    tick(2);
    wb(1'b0, 10'h010, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0002);
    check(input_gain_applied_o, 7'h02);
    tick(4);
    check(input_gain_applied_o, 7'h05);
    check(dac_gain_applied_o, 7'h03);
    wb(1'b0, 10'h010, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0003);
    $display("test gain stepping done");
    // interrupt status, mask and clear
    wb(1'b0, 10'h040, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0017);
    check(irq_o, 1'b0);
    wb(1'b1, 10'h044, 16'h0001, 4'h1, q);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    wb(1'b1, 10'h040, 16'h0001, 4'h1, q);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    wb(1'b1, 10'h044, 16'h003e, 4'h1, q);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    wb(1'b1, 10'h040, 16'h003f, 4'h1, q);
    wb(1'b0, 10'h040, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0000);
    check(irq_o, 1'b0);
    // unmapped place reads zero and keeps nothing
    wb(1'b1, 10'h080, 16'hffff, 4'h3, q);
    wb(1'b0, 10'h080, 16'h0000, 4'h0, q);
    check(q, 32'h0000_0000);
    $display("test interrupts and unmapped done");
    // input gain on the record reference, slow rate; dac fast
    input_gain_target_i <= 7'h03;
    wb(1'b1, 10'h010, 16'h000c, 4'h1, q);
    tick(2);
    check(input_gain_applied_o, 7'h05);
    check(dac_gain_applied_o, 7'h04);
    rtick(4);
    check(input_gain_applied_o, 7'h03);
    $display("test record reference done");
    conclude();
  end
endmodule // testbench
